// File: isp_pkg.sv
// constants for the primary-side controller of the isolated serial link
// assumes a 200 MHz reference clock; all counts derive from it
package isp_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 5;
	localparam int SCLK_HALF_NS   = 25;
	localparam int GLITCH_MIN_NS  = 10;
	localparam int SEL_SETUP_NS   = 10;
	localparam int TAIL_WAIT_NS   = 200;

	// least times round up to whole cycles
	localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GLITCH_MIN_CYC = (GLITCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SEL_SETUP_CYC  = (SEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAIL_WAIT_CYC  = (TAIL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int CNT_W          = 16;
	localparam int SYNC_W         = 3;
	localparam logic RST_SEL_N    = 1'h1;
	localparam logic RST_LEVEL    = 1'h0;

	// ----------------------------------------
	// controller states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ISP_IDLE  = 3'h0,
		ISP_SETUP = 3'h1,
		ISP_XFER  = 3'h2,
		ISP_TAIL  = 3'h3,
		ISP_HOLD  = 3'h4
	} isp_state_t;

endpackage

// File: isp_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes each bit is an independent level; no bus coherence across bits
`timescale 1ns/100ps
module isp_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst,
	// levels
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			meta_r <= '0;
			o_sync <= '0;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule // isp_sync

// File: isp_host.sv
// primary-side controller driving the isolated serial link pins
// assumes pins from the isolator are asynchronous; one isolator on this return line
`timescale 1ns/100ps

// What this block does
// - select is active low on the pin
// - one isolator only on this return input
// - no pin pulse shorter than 10 ns, except o_slow_in_a, which copies i_slow_a every cycle
// - filtered grade preferred in noisy systems
module isp_host #(
	parameter int DATA_W   = 8,
	parameter int HALF_CYC = isp_pkg::SCLK_HALF_CYC
) (
	// clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	// user command side
	input  wire logic              i_start,
	input  wire logic [DATA_W-1:0] i_tx_data,
	input  wire logic              i_use_delayed_clock_out,
	input  wire logic              i_slow_a,
	output logic                   o_busy,
	output logic                   o_done,
	output logic      [DATA_W-1:0] o_rx_data,
	output logic                   o_slow_b,
	// isolator primary-side pins
	output logic                   o_link_clock,
	output logic                   o_primary_data_in,
	output logic                   o_primary_select_in_n,
	output logic                   o_slow_in_a,
	input  wire logic              i_primary_data_out,
	input  wire logic              i_delayed_clock_out,
	input  wire logic              i_slow_out_b
);

	localparam int BIT_W = $clog2(DATA_W + 1);
	localparam logic [isp_pkg::CNT_W-1:0] HALF_LAST  = isp_pkg::CNT_W'(HALF_CYC - 1);
	localparam logic [isp_pkg::CNT_W-1:0] SETUP_LAST = isp_pkg::CNT_W'(isp_pkg::SEL_SETUP_CYC - 1);
	localparam logic [isp_pkg::CNT_W-1:0] TAIL_LAST  = isp_pkg::CNT_W'(isp_pkg::TAIL_WAIT_CYC - 1);
	localparam logic [BIT_W-1:0]          BITS_ALL   = BIT_W'(DATA_W);
	localparam logic [BIT_W-1:0]          BITS_LAST  = BIT_W'(DATA_W - 1);

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	logic [isp_pkg::SYNC_W-1:0] pins_sync;
	logic                       mi_s;
	logic                       delayed_clock_out_s;
	logic                       slowb_s;
	logic                       delayed_clock_out_prev_r;

	isp_sync #(
		.WIDTH (isp_pkg::SYNC_W)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_async   ({i_slow_out_b, i_delayed_clock_out, i_primary_data_out}),
		.o_sync    (pins_sync)
	);

	assign mi_s    = pins_sync[0];
	assign delayed_clock_out_s  = pins_sync[1];
	assign slowb_s = pins_sync[2];

	// ----------------------------------------
	// state and decode
	// ----------------------------------------
	isp_pkg::isp_state_t          state_r;
	logic [isp_pkg::CNT_W-1:0]    cnt_r;
	logic [BIT_W-1:0]             bits_r;
	logic [BIT_W-1:0]             rx_cnt_r;
	logic [DATA_W-1:0]            tx_sh_r;
	logic [DATA_W-1:0]            rx_sh_r;
	logic                         use_delayed_clock_out_r;

	wire half_tick  = (cnt_r == HALF_LAST);
	wire in_xfer    = (state_r == isp_pkg::ISP_XFER);
	wire fall_now   = in_xfer && half_tick && o_link_clock;
	wire delayed_clock_out_rise  = delayed_clock_out_s && !delayed_clock_out_prev_r;
	// own-clock mode samples at the falling edge: round trip must fit one whole period minus sync
	wire own_sample = !use_delayed_clock_out_r && fall_now;
	wire dly_sample = use_delayed_clock_out_r && delayed_clock_out_rise && (state_r != isp_pkg::ISP_IDLE);
	wire rx_full    = (rx_cnt_r == BITS_ALL);
	wire sample_evt = (own_sample || dly_sample) && !rx_full;
	wire last_bit   = (bits_r == BITS_LAST);
	wire tail_end   = rx_full || (cnt_r == TAIL_LAST);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_r               <= isp_pkg::ISP_IDLE;
			cnt_r                 <= '0;
			bits_r                <= '0;
			tx_sh_r               <= '0;
			use_delayed_clock_out_r            <= isp_pkg::RST_LEVEL;
			o_link_clock          <= isp_pkg::RST_LEVEL;
			o_primary_data_in     <= isp_pkg::RST_LEVEL;
			o_primary_select_in_n <= isp_pkg::RST_SEL_N;
			o_busy                <= 1'h0;
			o_done                <= 1'h0;
			o_rx_data             <= '0;
		end else begin
			o_done <= 1'h0;
			case (state_r)
				isp_pkg::ISP_IDLE: begin
					o_link_clock <= 1'h0;
					if (i_start) begin
						tx_sh_r               <= i_tx_data;
						o_primary_data_in     <= i_tx_data[DATA_W-1];
						o_primary_select_in_n <= 1'h0;
						use_delayed_clock_out_r            <= i_use_delayed_clock_out;
						cnt_r                 <= '0;
						bits_r                <= '0;
						o_busy                <= 1'h1;
						state_r               <= isp_pkg::ISP_SETUP;
					end
				end
				isp_pkg::ISP_SETUP: begin
					// select settles before the first edge so the select filter passes it
					if (cnt_r == SETUP_LAST) begin
						cnt_r   <= '0;
						state_r <= isp_pkg::ISP_XFER;
					end else begin
						cnt_r <= cnt_r + 1'h1;
					end
				end
				isp_pkg::ISP_XFER: begin
					if (half_tick) begin
						cnt_r        <= '0;
						// half period of many cycles keeps every pulse wide
						o_link_clock <= !o_link_clock;
						if (o_link_clock) begin
							bits_r <= bits_r + 1'h1;
							if (last_bit) begin
								state_r <= isp_pkg::ISP_TAIL;
							end else begin
								tx_sh_r           <= {tx_sh_r[DATA_W-2:0], 1'h0};
								o_primary_data_in <= tx_sh_r[DATA_W-2];
							end
						end
					end else begin
						cnt_r <= cnt_r + 1'h1;
					end
				end
				isp_pkg::ISP_TAIL: begin
					// delayed clock edges still in flight; a dead device ends on timeout
					if (tail_end) begin
						o_primary_select_in_n <= 1'h1;
						cnt_r                 <= '0;
						state_r               <= isp_pkg::ISP_HOLD;
					end else begin
						cnt_r <= cnt_r + 1'h1;
					end
				end
				isp_pkg::ISP_HOLD: begin
					// deselect stays high long enough to pass the select filter
					if (cnt_r == SETUP_LAST) begin
						o_rx_data <= rx_sh_r;
						o_done    <= 1'h1;
						o_busy    <= 1'h0;
						state_r   <= isp_pkg::ISP_IDLE;
					end else begin
						cnt_r <= cnt_r + 1'h1;
					end
				end
				default: begin
					state_r <= isp_pkg::ISP_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// return data capture
	// ----------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rx_sh_r     <= '0;
			rx_cnt_r    <= '0;
			delayed_clock_out_prev_r <= 1'h0;
		end else begin
			delayed_clock_out_prev_r <= delayed_clock_out_s;
			if (state_r == isp_pkg::ISP_IDLE && i_start) begin
				rx_cnt_r <= '0;
			end else if (sample_evt) begin
				rx_sh_r  <= {rx_sh_r[DATA_W-2:0], mi_s};
				rx_cnt_r <= rx_cnt_r + 1'h1;
			end
		end
	end

	// ----------------------------------------
	// slow channels
	// ----------------------------------------
	// levels only; the device samples them slowly, so short pulses may vanish
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_slow_in_a <= isp_pkg::RST_LEVEL;
			o_slow_b    <= isp_pkg::RST_LEVEL;
		end else begin
			o_slow_in_a <= i_slow_a;
			o_slow_b    <= slowb_s;
		end
	end

endmodule // isp_host

// File: isp_host_sva.sv
// port checker for the primary-side link controller
// assumes the default HALF_CYC of 5 cycles
`timescale 1ns/100ps
module isp_host_sva #(
	parameter int DATA_W   = 8,
	parameter int HALF_CYC = 5
) (
	// clock, reset, user side
	input wire logic              i_ref_clk,
	input wire logic              i_rst,
	input wire logic              i_start,
	input wire logic [DATA_W-1:0] i_tx_data,
	input wire logic              i_use_delayed_clock_out,
	input wire logic              i_slow_a,
	input wire logic              o_busy,
	input wire logic              o_done,
	input wire logic [DATA_W-1:0] o_rx_data,
	input wire logic              o_slow_b,
	// isolator pins
	input wire logic              o_link_clock,
	input wire logic              o_primary_data_in,
	input wire logic              o_primary_select_in_n,
	input wire logic              o_slow_in_a,
	input wire logic              i_primary_data_out,
	input wire logic              i_delayed_clock_out,
	input wire logic              i_slow_out_b
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	idle_sel_a: assert property (!o_busy |-> o_primary_select_in_n)
		else $error("select low while idle");
	sel_clk_a: assert property (o_primary_select_in_n |-> !o_link_clock)
		else $error("clock runs while deselected");
	sel_setup_a: assert property ($fell(o_primary_select_in_n) |-> !o_link_clock [*2])
		else $error("select setup too short");
	clk_high_a: assert property ($rose(o_link_clock) |-> o_link_clock [*5] ##1 !o_link_clock)
		else $error("clock high width wrong");
	data_hold_a: assert property (o_link_clock |-> $stable(o_primary_data_in))
		else $error("data moved while clock high");
	start_sel_a: assert property (i_start && !o_busy |=> o_busy && !o_primary_select_in_n)
		else $error("start not taken");
	xfer_len_a: assert property ($rose(o_busy) |-> ##[80:200] o_done)
		else $error("transfer length wrong");
	slow_fwd_a: assert property (!$past(i_rst) |-> o_slow_in_a == $past(i_slow_a))
		else $error("slow a not forwarded");
	slow_back_a: assert property (!$past(i_rst, 3) && !$past(i_rst, 2) && !$past(i_rst)
		|-> o_slow_b == $past(i_slow_out_b, 3)) else $error("slow b not returned");
	cover property (o_done && !o_busy);
	cover property (i_start && !o_busy && i_use_delayed_clock_out);
	cover property ($rose(o_slow_b));
endmodule // isp_host_sva

bind isp_host isp_host_sva #(.DATA_W(DATA_W), .HALF_CYC(HALF_CYC)) i_sva (.i_ref_clk, .i_rst, .i_start,
	.i_tx_data, .i_use_delayed_clock_out, .i_slow_a, .o_busy, .o_done, .o_rx_data, .o_slow_b, .o_link_clock,
	.o_primary_data_in, .o_primary_select_in_n, .o_slow_in_a, .i_primary_data_out, .i_delayed_clock_out,
	.i_slow_out_b);

// File: isp_iso_model.sv
// isolator model with a mode-0 peripheral behind its secondary side
// assumes fast paths are fixed delays and slow paths are polled
`timescale 1ns/100ps
module isp_iso_model #(
	parameter int         DLY  = 4,
	parameter logic [7:0] RESP = 8'h5A
) (
	// primary side
	input  wire logic       i_pwr,
	input  wire logic       i_link_clock,
	input  wire logic       i_data_in,
	input  wire logic       i_select_n,
	input  wire logic       i_slow_in_a,
	output wire logic       o_data_out,
	output wire logic       o_delayed_clock_out,
	output wire logic       o_slow_out_b,
	// secondary side
	input  wire logic       i_slow_in_b,
	output wire logic       o_slow_out_a,
	output logic      [7:0] o_got
);
	wire        sclk, mosi, ssn, dly_clk;
	logic       miso;
	logic       qa = 1'h0;
	logic       qb = 1'h0;
	logic [7:0] sh = 8'h00;
	logic       odd = 1'h0;
	// filtered grade: inertial delay swallows short pulses
	assign #DLY sclk = i_link_clock;
	assign #DLY mosi = i_data_in;
	assign #DLY ssn = i_select_n;
	assign #(2*DLY) dly_clk = i_link_clock;
	// a released peripheral toggles, so stale bits never look valid
	always @(sh or ssn)
		miso <= #DLY (ssn ? ~sh[7] : sh[7]);
	// response flips every frame so a stale capture cannot match
	always @(negedge ssn) begin
		odd = ~odd;
		sh = odd ? RESP : ~RESP;
	end
	always @(negedge sclk)
		if (!ssn)
			sh <= {sh[6:0], 1'h0};
	always @(posedge sclk)
		if (!ssn)
			o_got <= {o_got[6:0], mosi};
	// levels are polled every 2500 ns and pass 100 ns later, so dc stays right without refresh
	always #2500 {qa, qb} <= #100 {i_slow_in_a, i_slow_in_b};
	// dead or unpowered side floats every output but o_got; no-connect pin left out
	assign o_data_out = i_pwr ? miso : 1'hz;
	assign o_delayed_clock_out = i_pwr ? dly_clk : 1'hz;
	assign o_slow_out_a = i_pwr ? qa : 1'hz;
	assign o_slow_out_b = i_pwr ? qb : 1'hz;
endmodule // isp_iso_model

// File: isolated_spi_signal_paths_bench.sv
// bench for the primary-side controller against the isolator model
// assumes default controller parameters and one isolator on the return line
`timescale 1ns/100ps
module isolated_spi_signal_paths_bench;
	localparam logic [7:0] RESP = 8'hB4;
	logic       clk = 1'h0;
	logic       rst = 1'h1;
	logic       start = 1'h0;
	logic [7:0] tx = 8'h00;
	logic       use_delayed_clock_out = 1'h0;
	logic       slow_a = 1'h0;
	logic       slow_in_b = 1'h0;
	logic       pwr = 1'h1;
	// tracks the model's frame parity: odd frames answer RESP, even ones its inverse
	logic       rx_odd = 1'h0;
	int         err_count = 0;
	int         n_compared = 0;
	logic       busy, done, slow_b, lclk, din, seln, sia, sa_out;
	logic [7:0] rx, got;
	// board pull-downs keep a floating isolator from reading as unknown
	tri0        pdo, dck, sob;
	always #2.5 clk = ~clk;
	isp_host i_dut (.i_ref_clk(clk), .i_rst(rst), .i_start(start), .i_tx_data(tx), .i_use_delayed_clock_out(use_delayed_clock_out),
		.i_slow_a(slow_a), .o_busy(busy), .o_done(done), .o_rx_data(rx), .o_slow_b(slow_b), .o_link_clock(lclk),
		.o_primary_data_in(din), .o_primary_select_in_n(seln), .o_slow_in_a(sia), .i_primary_data_out(pdo),
		.i_delayed_clock_out(dck), .i_slow_out_b(sob));
	isp_iso_model #(.DLY(4), .RESP(RESP)) i_iso (.i_pwr(pwr), .i_link_clock(lclk), .i_data_in(din),
		.i_select_n(seln), .i_slow_in_a(sia), .o_data_out(pdo), .o_delayed_clock_out(dck), .o_slow_out_b(sob),
		.i_slow_in_b(slow_in_b), .o_slow_out_a(sa_out), .o_got(got));
	task automatic final_report;
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// entered at a falling edge; returns in the done cycle so starts chain
	task automatic xfer(input logic [7:0] d, input logic dm);
		int k;
		rx_odd = ~rx_odd;
		start = 1'h1;
		tx = d;
		use_delayed_clock_out = dm;
		@(negedge clk);
		start = 1'h0;
		for (k = 0; k < 300 && done !== 1'h1; k++)
			@(negedge clk);
		if (done !== 1'h1) begin
			cmp({7'h00, done}, 8'h01);
			final_report();
		end
	endtask
	task automatic t_modes;
		xfer(8'h3A, 1'h0);
		cmp(rx, rx_odd ? RESP : ~RESP);
		cmp(got, 8'h3A);
		xfer(8'hC5, 1'h1);
		cmp(rx, rx_odd ? RESP : ~RESP);
		cmp(got, 8'hC5);
	endtask
	task automatic t_dead;
		pwr = 1'h0;
		xfer(8'h81, 1'h1);
		cmp({7'h00, seln}, 8'h01);
		pwr = 1'h1;
	endtask
	task automatic t_slow;
		int k;
		slow_a = 1'h1;
		slow_in_b = 1'h1;
		for (k = 0; k < 600 && !(sa_out === 1'h1 && slow_b === 1'h1); k++)
			@(negedge clk);
		cmp({7'h00, sa_out}, 8'h01);
		cmp({7'h00, slow_b}, 8'h01);
		if (k == 600)
			final_report();
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'h0;
		@(negedge clk);
		t_modes();
		t_dead();
		t_modes();
		t_slow();
		final_report();
	end
endmodule // isolated_spi_signal_paths_bench
